// [hw/spi_sfr_ram_command_port.v]
// Functional notes
// - Instruction starts on select falling, ends on select rising.
// - Device shifts in 4-bit command then 12-bit address on rising clock.
// - Write data sampled on rising clock edges.
// - Read data driven onto serial output at falling clock edges.
// - Decode 0000 with address 000 reset, 0011 read, 0010 write.
// - Decode 1011 CRC read, 1010 CRC write, 1100 verified byte write.
// - CRC commands carry length byte and two-byte CRC over all fields.
// - Verified write checks CRC over command, address, data before commit.
// - Reset command restores registers, state machines, enters configuration mode.
// - Reset command leaves message RAM untouched.
// - Reset applied only when select rises at end of instruction.
// - Register access bytewise, address increments, wraps FFF to 000.
// - Plain register write commits on falling clock after 8th bit; last byte in mode 1,1 commits on select rise.
// - RAM access wordwise, address increments, wraps BFF to 400.
// - RAM address low two bits forced to zero.
// - RAM read fetches a word after address and every fourth byte.
// - RAM write stores each fourth byte; partial word dropped.
// - CRC-16 polynomial 8005 computed alongside shift register.
// - CRC preset to FFFF when select asserts.
// - Early select rise on a CRC or verified command flags frame error; write mismatch flags CRC error.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "spi_cmd_port_consts.vh"

module spi_sfr_ram_command_port #(
  parameter RAM_WORDS = 512,
  parameter RAM_AW    = 9
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Serial pins
  input  wire        sck,
  input  wire        selectLineN,
  input  wire        sdi,
  output reg         sdo,
  output wire        sdoOe,
  // Register file access
  output wire [11:0] sfrRdAddr,
  input  wire [7:0]  sfrRdData,
  output reg  [11:0] sfrWrAddr,
  output reg  [7:0]  sfrWrData,
  output reg         sfrWrEn,
  // Device control
  output reg         softResetPulse,
  output wire        configMode,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_HDR  = 6'h02;
  localparam [5:0] S_LEN  = 6'h04;
  localparam [5:0] S_DATA = 6'h08;
  localparam [5:0] S_CRC  = 6'h10;
  localparam [5:0] S_DONE = 6'h20;

  function [15:0] crcBit;
    input [15:0] c;
    input        b;
    begin
      crcBit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
    end
  endfunction

  function isRam;
    input [11:0] a;
    begin
      isRam = (a >= `RAM_LO) && (a <= `RAM_HI);
    end
  endfunction

  function [11:0] nextAddr;
    input [11:0] a;
    input        ram;
    begin
      if (ram && a == `RAM_HI)
        nextAddr = `RAM_LO;
      else
        nextAddr = a + 12'h001;
    end
  endfunction

  function [RAM_AW-1:0] ramIdx;
    input [11:0] a;
    reg   [11:0] off;
    begin
      off = a - `RAM_LO;
      ramIdx = off[RAM_AW+1:2];
    end
  endfunction

  reg [31:0] ram [0:RAM_WORDS-1];

  // Synchronisers; stage 0 feeds stage 1 only
  reg [2:0]  sckS;
  reg [2:0]  csS;
  reg [1:0]  sdiS;

  reg [5:0]  state;
  reg [3:0]  cnt;
  reg [15:0] hdr;
  reg [7:0]  rxByte;
  reg [11:0] addr;
  reg        ramSel;
  reg        isRead;
  reg        isCrc;
  reg        isSafe;
  reg        crcDone;
  reg        resetArmed;
  reg [9:0]  remain;
  reg [15:0] crc;
  reg [15:0] crcHold;
  reg [7:0]  txByte;
  reg [31:0] ramWord;
  reg [31:0] wordBuf;
  reg        pendWr;
  reg        pendRam;
  reg [11:0] wrAddr;
  reg [7:0]  wrData;
  reg [11:0] ramWrAddr;
  reg [31:0] ramWrData;

  reg        ctrlEn;
  reg        crcErrFlag;
  reg        frmErrFlag;
  reg        cfgFlag;
  reg [15:0] crcVal;

  wire sckRise = sckS[1] & ~sckS[2];
  wire sckFall = ~sckS[1] & sckS[2];
  wire csLow   = ~csS[1];
  wire csFall  = ~csS[1] & csS[2];
  wire csRise  = csS[1] & ~csS[2];
  wire active  = csLow & ctrlEn;
  wire outPhase = isRead & ((state == S_DATA) | (state == S_CRC));
  wire bitIn   = outPhase ? sdo : sdiS[1];
  wire [15:0] crcNext = crcBit(crc, bitIn);
  wire [15:0] hdrNext = {hdr[14:0], sdiS[1]};
  wire [7:0]  byteNext = {rxByte[6:0], sdiS[1]};
  wire [11:0] hAddr = hdrNext[11:0];
  wire        hRam = isRam(hAddr);
  wire [11:0] hAligned = hRam ? {hAddr[11:2], 2'b00} : hAddr;
  wire [11:0] aNext = nextAddr(addr, ramSel);
  wire [7:0]  curByte = ramSel ? ramWord[{addr[1:0], 3'b000} +: 8] : sfrRdData;
  wire        apbSetup = psel & ~penable;
  wire        apbAcc = psel & penable;
  wire        mapped = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) |
                       (paddr == `REG_CRCVAL);
  wire        stWr = apbAcc & pwrite & (paddr == `REG_STATUS);
  wire        cmdWrite = ~isRead;

  // Single-cycle answer: no wait states are ever inserted
  assign pready     = 1'b1;
  assign pslverr    = apbAcc & ~mapped;
  assign sfrRdAddr  = addr;
  assign sdoOe      = csLow & isRead & ctrlEn;
  assign configMode = cfgFlag;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sckS <= 3'h0;
      csS  <= 3'h7;
      sdiS <= 2'h0;
    end else begin
      sckS <= {sckS[1:0], sck};
      csS  <= {csS[1:0], selectLineN};
      sdiS <= {sdiS[0], sdi};
    end
  end

  // Write path to RAM; reset command never touches it
  always @(posedge clk) begin
    if (pendRam && ((sckFall && active) || csRise))
      ram[ramIdx(ramWrAddr)] <= ramWrData;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= S_IDLE;
      cnt        <= 4'h0;
      hdr        <= 16'h0000;
      rxByte     <= 8'h00;
      addr       <= 12'h000;
      ramSel     <= 1'b0;
      isRead     <= 1'b0;
      isCrc      <= 1'b0;
      isSafe     <= 1'b0;
      crcDone    <= 1'b0;
      resetArmed <= 1'b0;
      remain     <= 10'h000;
      crc        <= `CRC_INIT;
      crcHold    <= 16'h0000;
      txByte     <= 8'h00;
      ramWord    <= 32'h00000000;
      wordBuf    <= 32'h00000000;
      pendWr     <= 1'b0;
      pendRam    <= 1'b0;
      wrAddr     <= 12'h000;
      wrData     <= 8'h00;
      ramWrAddr  <= 12'h000;
      ramWrData  <= 32'h00000000;
      sdo        <= 1'b0;
      sfrWrAddr  <= 12'h000;
      sfrWrData  <= 8'h00;
      sfrWrEn    <= 1'b0;
      softResetPulse <= 1'b0;
    end else begin
      sfrWrEn        <= 1'b0;
      softResetPulse <= 1'b0;
      if (csFall) begin
        state      <= S_HDR;
        cnt        <= 4'h0;
        crc        <= `CRC_INIT;
        isRead     <= 1'b0;
        isCrc      <= 1'b0;
        isSafe     <= 1'b0;
        crcDone    <= 1'b0;
        resetArmed <= 1'b0;
      end else if (csRise) begin
        // Mode 1,1 ends on a rising edge, so pending commits finish here
        if (pendWr) begin
          sfrWrEn   <= 1'b1;
          sfrWrAddr <= wrAddr;
          sfrWrData <= wrData;
        end
        pendWr  <= 1'b0;
        pendRam <= 1'b0;
        isRead  <= 1'b0;
        state   <= S_IDLE;
        if (resetArmed && state == S_DONE)
          softResetPulse <= 1'b1;
      end else if (active && sckRise) begin
        if (state != S_DONE)
          crc <= crcNext;
        case (state)
          S_HDR: begin
            hdr <= hdrNext;
            cnt <= cnt + 4'h1;
            if (cnt == 4'hF) begin
              cnt    <= 4'h0;
              addr   <= hAligned;
              ramSel <= hRam;
              case (hdrNext[15:12])
                `CMD_READ: begin
                  isRead  <= 1'b1;
                  state   <= S_DATA;
                  ramWord <= ram[ramIdx(hAligned)];
                end
                `CMD_WRITE: state <= S_DATA;
                `CMD_READ_CRC: begin
                  isRead <= 1'b1;
                  isCrc  <= 1'b1;
                  state  <= S_LEN;
                end
                `CMD_WRITE_CRC: begin
                  isCrc <= 1'b1;
                  state <= S_LEN;
                end
                `CMD_WRITE_SAFE: begin
                  isSafe <= 1'b1;
                  remain <= 10'h001;
                  state  <= S_DATA;
                end
                default: begin
                  state      <= S_DONE;
                  resetArmed <= (hdrNext[15:12] == `CMD_RESET) &&
                                (hAddr == `ADDR_RESET);
                end
              endcase
            end
          end
          S_LEN: begin
            rxByte <= byteNext;
            cnt    <= cnt + 4'h1;
            if (cnt == 4'h7) begin
              cnt     <= 4'h0;
              remain  <= ramSel ? {byteNext, 2'b00} : {2'b00, byteNext};
              ramWord <= ram[ramIdx(addr)];
              if (byteNext == 8'h00) begin
                state   <= S_CRC;
                crcHold <= crcNext;
              end else begin
                state <= S_DATA;
              end
            end
          end
          S_DATA: begin
            rxByte <= byteNext;
            cnt    <= cnt + 4'h1;
            if (cnt == 4'h7) begin
              cnt  <= 4'h0;
              addr <= aNext;
              if (cmdWrite) begin
                wrAddr <= addr;
                wrData <= byteNext;
                if (!isSafe && !ramSel)
                  pendWr <= 1'b1;
                if (ramSel) begin
                  wordBuf[{addr[1:0], 3'b000} +: 8] <= byteNext;
                  if (addr[1:0] == 2'b11) begin
                    pendRam   <= 1'b1;
                    ramWrAddr <= addr;
                    ramWrData <= {byteNext, wordBuf[23:0]};
                  end
                end
              end else if (ramSel && addr[1:0] == 2'b11) begin
                ramWord <= ram[ramIdx(aNext)];
              end
              if (isCrc || isSafe) begin
                remain <= remain - 10'h001;
                if (remain == 10'h001) begin
                  state   <= S_CRC;
                  crcHold <= crcNext;
                end
              end
            end
          end
          S_CRC: begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'hF) begin
              crcDone <= 1'b1;
              state   <= S_DONE;
              // Residue is zero when the received CRC matches
              if (cmdWrite && crcNext == 16'h0000 && isSafe)
                pendWr <= 1'b1;
            end
          end
          default: state <= state;
        endcase
      end else if (active && sckFall) begin
        if (pendWr) begin
          sfrWrEn   <= 1'b1;
          sfrWrAddr <= wrAddr;
          sfrWrData <= wrData;
          pendWr    <= 1'b0;
        end
        pendRam <= 1'b0;
        if (isRead && state == S_DATA) begin
          if (cnt == 4'h0) begin
            txByte <= curByte;
            sdo    <= curByte[7];
          end else begin
            sdo <= txByte[3'h7 - cnt[2:0]];
          end
        end else if (isRead && state == S_CRC) begin
          sdo <= crcHold[4'hF - cnt];
        end
      end
    end
  end

  // Flags: hardware set wins over a same-cycle software clear
  wire setCrcErr = active && sckRise && state == S_CRC && cnt == 4'hF &&
                   cmdWrite && crcNext != 16'h0000;
  wire setFrmErr = csRise && (isCrc || isSafe) && !crcDone &&
                   state != S_DONE;
  wire doReset   = csRise && resetArmed && state == S_DONE;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlEn     <= `CTRL_RST;
      crcErrFlag <= 1'b0;
      frmErrFlag <= 1'b0;
      cfgFlag    <= 1'b1;
      crcVal     <= `CRCVAL_RST;
      prdata     <= 32'h00000000;
    end else begin
      if (doReset) begin
        crcErrFlag <= 1'b0;
        frmErrFlag <= 1'b0;
        cfgFlag    <= 1'b1;
        crcVal     <= `CRCVAL_RST;
      end else begin
        crcErrFlag <= setCrcErr | (crcErrFlag &
                      ~(stWr & pwdata[`ST_CRCERR_BIT]));
        frmErrFlag <= setFrmErr | (frmErrFlag &
                      ~(stWr & pwdata[`ST_FRMERR_BIT]));
        cfgFlag    <= cfgFlag & ~(stWr & pwdata[`ST_CFG_BIT]);
        if (setCrcErr)
          crcVal <= crcHold;
      end
      if (apbAcc && pwrite && paddr == `REG_CTRL)
        ctrlEn <= pwdata[`CTRL_EN_BIT];
      if (apbSetup) begin
        case (paddr)
          `REG_CTRL:   prdata <= {31'h00000000, ctrlEn};
          `REG_STATUS: prdata <= {29'h00000000, cfgFlag, frmErrFlag, crcErrFlag};
          `REG_CRCVAL: prdata <= {16'h0000, crcVal};
          default:     prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [hw/spi_cmd_port_consts.vh]
`ifndef SPI_CMD_PORT_CONSTS_VH
`define SPI_CMD_PORT_CONSTS_VH

// Serial command codes
`define CMD_RESET       4'h0
`define CMD_WRITE       4'h2
`define CMD_READ        4'h3
`define CMD_WRITE_CRC   4'hA
`define CMD_READ_CRC    4'hB
`define CMD_WRITE_SAFE  4'hC

// Address map seen over the serial port
`define ADDR_RESET      12'h000
`define ADDR_MAX        12'hFFF
`define RAM_LO          12'h400
`define RAM_HI          12'hBFF

// CRC engine
`define CRC_POLY        16'h8005
`define CRC_INIT        16'hFFFF

// APB register offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_CRCVAL      8'h08

// Field positions
`define CTRL_EN_BIT     0
`define ST_CRCERR_BIT   0
`define ST_FRMERR_BIT   1
`define ST_CFG_BIT      2

// Reset values
`define CTRL_RST        1'h1
`define CRCVAL_RST      16'h0000

`endif

// [dv/spi_cmd_port_checker_assertions.sv]
`timescale 1ns/1ps
module spi_cmd_port_checker (
  // Clock and reset
  input wire        clk,
  input wire        rstn,
  // Serial pins
  input wire        sck,
  input wire        selectLineN,
  input wire        sdo,
  input wire        sdoOe,
  // Device side
  input wire        sfrWrEn,
  input wire        softResetPulse,
  input wire        configMode,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wr_strobe_a: assert property (sfrWrEn |-> (!sck || selectLineN) ##1 !sfrWrEn)
    else $error("register write strobe misplaced");
  rst_close_a: assert property (softResetPulse |-> selectLineN)
    else $error("reset applied inside frame");
  rst_effect_a: assert property (softResetPulse |-> ##[0:2] configMode)
    else $error("reset left configuration mode off");
  rst_once_a: assert property (softResetPulse |=> !softResetPulse)
    else $error("reset pulse too long");
  oe_idle_a: assert property (selectLineN [*5] |-> !sdoOe)
    else $error("output driven while deselected");
  sdo_fall_a: assert property (sdoOe && $past(sdoOe) && $changed(sdo) |-> !sck)
    else $error("output changed while clock high");
  err_map_a: assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("slave error on wrong address");
  err_data_a: assert property (psel && penable && pslverr |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");
  cfg_clear_a: assert property ($fell(configMode)
    |-> $past(psel && penable && pwrite && paddr == 8'h04 && pwdata[2]))
    else $error("configuration mode lost without clear");
  cover property (sfrWrEn);
  cover property (softResetPulse);
  cover property (psel && penable && pslverr);
  cover property (sdoOe && sck);
endmodule

bind spi_sfr_ram_command_port spi_cmd_port_checker i_chk (
  .clk, .rstn, .sck, .selectLineN, .sdo, .sdoOe, .sfrWrEn, .softResetPulse, .configMode,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr);

// [dv/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
  // Core clock
  input  wire logic clk,
  // Serial pins
  output logic      sck,
  output logic      selectLineN,
  output logic      sdi,
  input  wire logic sdo
);
  logic txBit = 1'b0;
  logic busy  = 1'b0;
  logic mode1 = 1'b0;
  initial begin
    sck = 1'b0;
    selectLineN = 1'b1;
    sdi = 1'b0;
  end
  // Idle data line toggles so a stale bit never passes for data
  always @(posedge clk) sdi <= busy ? txBit : ~sdi;
  task automatic half();
    #62.5;
  endtask
  task automatic open_frame(input logic m);
    @(posedge clk);
    sck <= m;
    mode1 = m;
    half();
    selectLineN <= 1'b0;
    busy <= 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (mode1) sck <= 1'b0;
      txBit <= tx[i];
      half();
      rx[i] = sdo;
      sck <= 1'b1;
      half();
      if (!mode1) sck <= 1'b0;
    end
  endtask
  task automatic close_frame();
    half();
    selectLineN <= 1'b1;
    busy <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
endmodule

// [dv/spi_sfr_ram_command_port_bench.sv]
`timescale 1ns/1ps
module spi_sfr_ram_command_port_bench;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  wire         sck, selectLineN, sdi, sdo, sdoOe, sfrWrEn;
  wire         softResetPulse, configMode, pready, pslverr;
  wire  [11:0] sfrRdAddr, sfrWrAddr;
  wire  [7:0]  sfrRdData, sfrWrData;
  wire  [31:0] prdata;
  wire         sdoPin;
  logic [7:0]  sfrMem [4096];
  logic [19:0] wrLog [$];
  logic [7:0]  tx [$];
  logic [7:0]  rx [$];
  int          errors = 0;
  int          tests_run = 0;
  int          resets = 0;
  always #4 clk = ~clk;
  initial foreach (sfrMem[i]) sfrMem[i] = 8'h00;
  assign sfrRdData = sfrMem[sfrRdAddr];
  always @(posedge clk) begin
    if (sfrWrEn === 1'b1) begin
      wrLog.push_back({sfrWrAddr, sfrWrData});
      sfrMem[sfrWrAddr] <= sfrWrData;
    end
    if (softResetPulse === 1'b1) resets++;
  end
  // Floating line shows the inverse so stale data cannot pass
  assign sdoPin = sdoOe ? sdo : ~sdo;
  spi_host_model i_host (.clk, .sck, .selectLineN, .sdi, .sdo(sdoPin));
  spi_sfr_ram_command_port i_dut (.clk, .rstn, .sck, .selectLineN, .sdi, .sdo, .sdoOe,
    .sfrRdAddr, .sfrRdData, .sfrWrAddr, .sfrWrData, .sfrWrEn, .softResetPulse,
    .configMode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errors++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic m);
    logic [7:0] b;
    rx = {};
    wrLog = {};
    i_host.open_frame(m);
    foreach (tx[i]) begin
      i_host.xfer(tx[i], b);
      rx.push_back(b);
    end
    i_host.close_frame();
  endtask
  task automatic pushw(input logic [31:0] w);
    for (int k = 0; k < 4; k++) tx.push_back(w[8*k +: 8]);
  endtask
  function automatic logic [31:0] word(input int i);
    return {rx[i+3], rx[i+2], rx[i+1], rx[i]};
  endfunction
  function automatic logic [15:0] crc(input int n);
    logic [15:0] c = 16'hFFFF;
    for (int j = 0; j < n; j++)
      for (int i = 7; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ tx[j][i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r, w0, w1, w2;
    logic [7:0]  d0, d1, d2;
    logic [15:0] c;
    logic        e;
    void'($urandom(32'h2c92e08c));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0, r, e);
    chk("ctrl", 32'h1, r);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("status", 3'b100, r[2:0]);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("crcval", 32'h0, r);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    chk("pslverr", 1'b1, e);
    for (int m = 0; m < 2; m++) begin
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      tx = {8'h2F, 8'hFE, d0, d1, d2};
      frame(m[0]);
      chk("wrcount", 3, wrLog.size());
      chk("wr0", {12'hFFE, d0}, wrLog[0]);
      chk("wr2", {12'h000, d2}, wrLog[2]);
      tx = {8'h3F, 8'hFF, 8'h00, 8'h00};
      frame(m[0]);
      chk("rd0", d1, rx[2]);
      chk("rd1", d2, rx[3]);
    end
    w0 = $urandom;
    w1 = $urandom;
    w2 = $urandom;
    tx = {8'h24, 8'h04};
    pushw(w0);
    frame(1'b0);
    tx = {8'h2B, 8'hFE, d0, d1};
    pushw(w1);
    pushw(w2);
    tx = {tx[0:1], tx[4:11], d0, d1};
    frame(1'b0);
    chk("ramsfr", 0, wrLog.size());
    tx = {8'h3B, 8'hFC};
    repeat (12) tx.push_back(8'h00);
    frame(1'b0);
    chk("ramBFC", w1, word(2));
    chk("ram400", w2, word(6));
    chk("ram404", w0, word(10));
    tx = {8'hA0, 8'h10, 8'h02, d0, d1};
    c = crc(5);
    tx = {tx, c[15:8], c[7:0]};
    frame(1'b0);
    chk("crcwr", {12'h011, d1}, wrLog[1]);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("crcgood", 2'b00, r[1:0]);
    tx[6] = tx[6] ^ 8'h01;
    frame(1'b0);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("crcbad", 1'b1, r[0]);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("crcval", c, r[15:0]);
    tx = {8'hB0, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    frame(1'b0);
    chk("rdcrc", {d0, d1}, {rx[3], rx[4]});
    tx[3] = rx[3];
    tx[4] = rx[4];
    chk("rdcrcsum", crc(5), {rx[5], rx[6]});
    tx = {8'hA4, 8'h08, 8'h01};
    pushw(w2);
    c = crc(7);
    tx = {tx, c[15:8], c[7:0]};
    frame(1'b0);
    tx = {8'hB4, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    frame(1'b0);
    chk("ramcrc", w2, word(3));
    tx = {8'hC0, 8'h20, d2};
    c = crc(3);
    tx = {tx, c[15:8], c[7:0]};
    frame(1'b0);
    chk("safe", {12'h020, d2}, wrLog[0]);
    tx[4] = tx[4] ^ 8'h80;
    frame(1'b0);
    chk("safebad", 0, wrLog.size());
    apb(1'b1, 8'h04, 32'h3, r, e);
    tx = {8'hA0, 8'h30, 8'h01, d0};
    frame(1'b0);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("short", 2'b10, r[1:0]);
    tx = {8'h20, 8'h40, d0};
    frame(1'b0);
    chk("single", {12'h040, d0}, wrLog[0]);
    tx = {8'h00, 8'h01, d2};
    frame(1'b0);
    chk("badrst", 0, resets + wrLog.size());
    i_host.open_frame(1'b0);
    i_host.xfer(8'h00, d0);
    i_host.xfer(8'h00, d0);
    repeat (40) @(posedge clk);
    chk("rstearly", 0, resets);
    i_host.close_frame();
    chk("rstdone", 1, resets);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("rststat", 3'b100, r[2:0]);
    tx = {8'h34, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    frame(1'b0);
    chk("ramkept", w0, word(2));
    apb(1'b1, 8'h04, 32'h4, r, e);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("cfgclear", 1'b0, r[2]);
    tally_and_finish();
  end
endmodule
